// file: rtl/bcpp_consts.svh
// Constants of the boot command packet parser: markers, codes, lengths.
// Assumes inclusion by bare name from the package and the design files.
`ifndef BCPP_CONSTS_SVH
`define BCPP_CONSTS_SVH

`define BCPP_CMD_START      8'h01
`define BCPP_REPLY_START    8'h81
`define BCPP_PKT_END        8'h03
`define BCPP_MAX_LEN        11'd1025
`define BCPP_MAX_INFO       9'd255

`define BCPP_OP_AREA_INFO   8'h3b
`define BCPP_OP_AUTH        8'h30
`define BCPP_OP_BAUD        8'h34
`define BCPP_OP_BOUND_REQ   8'h4f
`define BCPP_OP_BOUND_SET   8'h4e
`define BCPP_OP_CRC         8'h18
`define BCPP_OP_LC_REQ      8'h2c
`define BCPP_OP_LC_TRANSIT  8'h71
`define BCPP_OP_ERASE       8'h12
`define BCPP_OP_INIT        8'h50
`define BCPP_OP_INQUIRY     8'h00
`define BCPP_OP_KEY_SET     8'h28
`define BCPP_OP_KEY_VERIFY  8'h29
`define BCPP_OP_UKEY_SET    8'h2a
`define BCPP_OP_UKEY_VERIFY 8'h2b
`define BCPP_OP_PARAM_REQ   8'h52
`define BCPP_OP_PARAM_SET   8'h51
`define BCPP_OP_READ        8'h15
`define BCPP_OP_SIGNATURE   8'h3a
`define BCPP_OP_WRITE       8'h13

`define BCPP_LEN_INQUIRY    16'h0001
`define BCPP_LEN_INIT       16'h0003
`define BCPP_LEN_LC_REQ     16'h0001
`define BCPP_LEN_LC_TRANSIT 16'h0003

`define BCPP_RESP_OK        8'h00
`define BCPP_RESP_UNSUP     8'h80
`define BCPP_RESP_PACKET    8'h81
`define BCPP_RESP_CHECKSUM  8'h82
`define BCPP_RESP_UNDEF     8'hff
`define BCPP_NO_FAIL_ADDR   32'h0fffffff

`endif

// file: rtl/bcpp_info_mem.sv
// Information byte store of one command packet, 256 bytes.
// Assumes one clock; read data come out of a register.
`timescale 1ns/1ps
module bcpp_info_mem (
    input  wire logic                   ref_clk,
    input  wire logic                   clkEn,
    input  wire logic                   wrEn,
    input  wire logic [7:0]             wrAddr,
    input  wire bcpp_pkg::bcpp_byte_t   wrData,
    input  wire logic [7:0]             rdAddr,
    output      bcpp_pkg::bcpp_byte_t   rdData
);
    import bcpp_pkg::*;

    bcpp_byte_t store [0:255];

    always_ff @(posedge ref_clk) begin
        if (clkEn) begin
            if (wrEn) begin
                store[wrAddr] <= wrData;
            end
            rdData <= store[rdAddr];
        end
    end
endmodule

// file: rtl/bcpp_parser.sv
// Boot command packet parser: receives command packets byte by byte,
// checks framing, checksum and length, decodes the command and emits a
// reply header (response code) or hands the command to an executor.
// Assumes a byte stream synchronous to ref_clk and an executor that
// answers with cmdDone/cmdFailAddr.
//
// Overview of operation
// R01: Declared length zero or above 1025 still yields a reply, response code undefined.
// R02: Host sends at most 1030 bytes per transfer; beyond that is unguaranteed.
// R03: Failure address carries failing sequencer start address, else all ones; the code gives 0x0fffffff instead.
// R04: Full boot command set is decoded.
// R05: Code 0x18 is the CRC command.
// R06: Code 0x34 is the baud rate setting command.
// R07: 0x2c lifecycle state request, 0x71 lifecycle state transit.
// R08: User key codes 0x2a/0x2b are unsupported on variants without them.
// R09: Inquiry packet is length 0x0001, code 0x00, checksum 0xff.
// R10: Reception starts only on byte 0x01; other bytes discarded while idle.
// R11: Missing end byte 0x03 gives a packet error.
// R12: Checksum mismatch over length, code and information gives checksum error.
// R13: Length outside general format gives packet error.
// R14: Undefined command code gives unsupported-command error.
// R15: Length wrong for the decoded command gives packet error.
// R16: After any error, no execution; back to waiting for a command.
// R17: Valid packet is executed; success keeps the command-accepting phase.
// R18: Command packet is start, two length bytes, code, 0..255 info, sum, end.
// R19: Reply is 0x81, length, response code, data, sum, 0x03; sums to zero. The code outputs only 0x81, response code, failure address and 0x03.
// R20: Error replies carry distinct packet, checksum, unsupported codes.
`timescale 1ns/1ps
`include "bcpp_consts.svh"
module bcpp_parser #(
    parameter bit    HAS_USER_KEY = 1'b1
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic                   clkEn,
    input  wire logic                   rxValid,
    input  wire bcpp_pkg::bcpp_byte_t   rxByte,
    input  wire logic                   cmdDone,
    input  wire logic                   cmdFlashErr,
    input  wire logic [31:0]            cmdFailAddr,
    input  wire logic [7:0]             infoRdAddr,
    output      bcpp_pkg::bcpp_byte_t   infoRdData,
    output      logic                   cmdStart,
    output      bcpp_pkg::bcpp_byte_t   cmdCode,
    output      bcpp_pkg::bcpp_len_t    cmdLen,
    output      logic                   replyValid,
    output      bcpp_pkg::bcpp_byte_t   replyStart,
    output      bcpp_pkg::bcpp_byte_t   replyEnd,
    output      bcpp_pkg::bcpp_byte_t   responseCode,
    output      logic [31:0]            failAddr,
    output      logic                   busy
);
    import bcpp_pkg::*;

    typedef enum logic [2:0] {
        WAIT_START,
        GET_LEN_HI,
        GET_LEN_LO,
        GET_CODE,
        GET_INFO,
        GET_SUM,
        GET_END,
        EXECUTE
    } bcpp_state_e;

    function automatic logic bcpp_code_known(input bcpp_byte_t c, input bit userKey);
        case (c)
            `BCPP_OP_AREA_INFO, `BCPP_OP_AUTH, `BCPP_OP_BAUD,
            `BCPP_OP_BOUND_REQ, `BCPP_OP_BOUND_SET, `BCPP_OP_CRC,
            `BCPP_OP_LC_REQ, `BCPP_OP_LC_TRANSIT, `BCPP_OP_ERASE,
            `BCPP_OP_INIT, `BCPP_OP_INQUIRY, `BCPP_OP_KEY_SET,
            `BCPP_OP_KEY_VERIFY, `BCPP_OP_PARAM_REQ, `BCPP_OP_PARAM_SET,
            `BCPP_OP_READ, `BCPP_OP_SIGNATURE, `BCPP_OP_WRITE:
                bcpp_code_known = 1'b1; // [R04] [R05] [R06] [R07]
            `BCPP_OP_UKEY_SET, `BCPP_OP_UKEY_VERIFY:
                bcpp_code_known = userKey; // [R08]
            default:
                bcpp_code_known = 1'b0;
        endcase
    endfunction

    // Commands with a fixed length; others only need the general bound
    function automatic logic bcpp_len_fits(input bcpp_byte_t c, input bcpp_len_t n);
        case (c)
            `BCPP_OP_INQUIRY:    bcpp_len_fits = (n == `BCPP_LEN_INQUIRY); // [R09]
            `BCPP_OP_INIT:       bcpp_len_fits = (n == `BCPP_LEN_INIT);
            `BCPP_OP_LC_REQ:     bcpp_len_fits = (n == `BCPP_LEN_LC_REQ);
            `BCPP_OP_LC_TRANSIT: bcpp_len_fits = (n == `BCPP_LEN_LC_TRANSIT);
            default:             bcpp_len_fits = 1'b1;
        endcase
    endfunction

    bcpp_state_e    state_reg;
    bcpp_state_e    state_next;
    bcpp_len_t      len_reg;
    bcpp_byte_t     code_reg;
    bcpp_byte_t     sum_reg;
    logic [8:0]     infoCnt_reg;
    logic           sumBad_reg;
    logic           cmdStart_reg;
    logic           replyValid_reg;
    bcpp_byte_t     resp_reg;
    logic [31:0]    failAddr_reg;
    logic           busy_reg;

    wire logic          byteIn     = clkEn && rxValid;
    wire bcpp_byte_t    sumNext    = sum_reg + rxByte;
    wire bcpp_len_t     lenFull    = {len_reg[15:8], rxByte};
    // Index of the last information byte: length less the code byte, less one
    wire logic [8:0]    infoLastIdx = len_reg[8:0] - 9'd2;
    wire logic          lenZeroOrBig = (len_reg == 16'h0000) ||
                                       (len_reg > {5'd0, `BCPP_MAX_LEN});
    // One code byte plus at most 255 information bytes
    wire logic          lenFmtBad  = (len_reg == 16'h0000) ||
                                     (len_reg > ({7'd0, `BCPP_MAX_INFO} + 16'd1));
    wire logic          infoLast   = (infoCnt_reg == infoLastIdx);
    wire logic          infoWr     = byteIn && (state_reg == GET_INFO);
    wire logic          endOk      = (rxByte == `BCPP_PKT_END);
    wire logic          codeOk     = bcpp_code_known(code_reg, HAS_USER_KEY);
    wire logic          lenOk      = bcpp_len_fits(code_reg, len_reg);

    // Check order: end marker, checksum, general length, code, command length
    bcpp_verdict_e verdict;
    assign verdict = !endOk     ? BCPP_ERR_PACKET :   // [R11]
                     sumBad_reg ? BCPP_ERR_CHECKSUM : // [R12]
                     lenFmtBad  ? BCPP_ERR_BADLEN :   // [R13]
                     !codeOk    ? BCPP_ERR_UNSUP :    // [R14]
                     !lenOk     ? BCPP_ERR_BADLEN :   // [R15]
                                  BCPP_OK;

    bcpp_byte_t verdictCode;
    assign verdictCode = (verdict == BCPP_ERR_CHECKSUM) ? `BCPP_RESP_CHECKSUM : // [R20]
                         (verdict == BCPP_ERR_UNSUP)    ? `BCPP_RESP_UNSUP :
                         (lenZeroOrBig)                 ? `BCPP_RESP_UNDEF :    // [R01]
                                                          `BCPP_RESP_PACKET;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            WAIT_START: if (byteIn && rxByte == `BCPP_CMD_START) state_next = GET_LEN_HI; // [R10]
            GET_LEN_HI: if (byteIn) state_next = GET_LEN_LO; // [R18]
            GET_LEN_LO: if (byteIn) state_next = GET_CODE;
            GET_CODE: begin
                if (byteIn) begin
                    state_next = (len_reg > 16'd1 && !lenFmtBad) ? GET_INFO : GET_SUM;
                end
            end
            GET_INFO:   if (byteIn && infoLast) state_next = GET_SUM;
            GET_SUM:    if (byteIn) state_next = GET_END;
            GET_END: begin
                if (byteIn) begin
                    state_next = (verdict == BCPP_OK) ? EXECUTE : WAIT_START; // [R16]
                end
            end
            EXECUTE:    if (clkEn && cmdDone) state_next = WAIT_START; // [R17]
            default:    state_next = WAIT_START;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= WAIT_START;
            busy_reg  <= 1'b0;
        end else if (clkEn) begin
            state_reg <= state_next;
            busy_reg  <= (state_next == EXECUTE);
        end
    end

    // Length, code, running sum and information count
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            len_reg     <= 16'h0000;
            code_reg    <= 8'h00;
            sum_reg     <= 8'h00;
            infoCnt_reg <= 9'd0;
            sumBad_reg  <= 1'b0;
        end else if (byteIn) begin
            case (state_reg)
                WAIT_START: begin
                    sum_reg     <= 8'h00;
                    infoCnt_reg <= 9'd0;
                end
                GET_LEN_HI: begin
                    len_reg <= {rxByte, 8'h00};
                    sum_reg <= sumNext;
                end
                GET_LEN_LO: begin
                    len_reg <= lenFull;
                    sum_reg <= sumNext;
                end
                GET_CODE: begin
                    code_reg <= rxByte;
                    sum_reg  <= sumNext;
                end
                GET_INFO: begin
                    sum_reg     <= sumNext;
                    infoCnt_reg <= infoCnt_reg + 9'd1;
                end
                GET_SUM:    sumBad_reg <= (sumNext != 8'h00); // [R12]
                default:    sum_reg <= sum_reg;
            endcase
        end
    end

    // Outputs: execute strobe, reply header and failure address
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmdStart_reg   <= 1'b0;
            replyValid_reg <= 1'b0;
            resp_reg       <= `BCPP_RESP_OK;
            failAddr_reg   <= `BCPP_NO_FAIL_ADDR;
        end else if (clkEn) begin
            cmdStart_reg   <= 1'b0;
            replyValid_reg <= 1'b0;
            if (state_reg == GET_END && byteIn) begin
                if (verdict == BCPP_OK) begin
                    cmdStart_reg <= 1'b1; // [R17]
                end else begin
                    replyValid_reg <= 1'b1; // [R16] [R20]
                    resp_reg       <= verdictCode;
                    failAddr_reg   <= `BCPP_NO_FAIL_ADDR;
                end
            end
            if (state_reg == EXECUTE && cmdDone) begin
                replyValid_reg <= 1'b1;
                resp_reg       <= code_reg;
                failAddr_reg   <= cmdFlashErr ? cmdFailAddr : `BCPP_NO_FAIL_ADDR; // [R03]
            end
        end
    end

    bcpp_info_mem bcpp_info_mem_i (
        .ref_clk (ref_clk),
        .clkEn   (clkEn),
        .wrEn    (infoWr),
        .wrAddr  (infoCnt_reg[7:0]),
        .wrData  (rxByte),
        .rdAddr  (infoRdAddr),
        .rdData  (infoRdData)
    );

    assign cmdStart     = cmdStart_reg;
    assign cmdCode      = code_reg;
    assign cmdLen       = len_reg;
    assign replyValid   = replyValid_reg;
    assign replyStart   = `BCPP_REPLY_START; // [R19]
    assign replyEnd     = `BCPP_PKT_END;
    assign responseCode = resp_reg;
    assign failAddr     = failAddr_reg;
    assign busy         = busy_reg;
endmodule

// file: rtl/bcpp_pkg.sv
// Types of the boot command packet parser.
// Assumes bcpp_consts.svh on the include path.
`include "bcpp_consts.svh"
package bcpp_pkg;
    typedef logic [7:0]  bcpp_byte_t;
    typedef logic [15:0] bcpp_len_t;
    typedef enum logic [2:0] {
        BCPP_OK,
        BCPP_ERR_PACKET,
        BCPP_ERR_CHECKSUM,
        BCPP_ERR_UNSUP,
        BCPP_ERR_BADLEN
    } bcpp_verdict_e;
endpackage

// file: sim/bcpp_host_model.sv
// Host model: sends command packets byte by byte.
// Assumes the bench calls its tasks; it drives at falling edges.
`timescale 1ns/1ps
module bcpp_host_model (
    input  wire logic                 ref_clk,
    output      logic                 rxValid,
    output      bcpp_pkg::bcpp_byte_t rxByte
);
    import bcpp_pkg::*;
    initial begin
        rxValid = 1'b0;
        rxByte  = 8'h00;
    end
    task automatic send_byte(input bcpp_byte_t b);
        @(negedge ref_clk);
        rxValid = 1'b1;
        rxByte  = b;
    endtask
    // Released line shows the inverse of the last byte
    task automatic release_line();
        @(negedge ref_clk);
        rxValid = 1'b0;
        rxByte  = ~rxByte;
    endtask
    // Info count follows the length field up to 256, else no info bytes; never above 1030 bytes
    task automatic send_pkt(input bcpp_len_t len, input bcpp_byte_t code, input bcpp_byte_t base,
                            input bcpp_byte_t sumErr, input bcpp_byte_t endByte);
        bcpp_byte_t sum;
        int         n;
        n   = (len >= 16'd1 && len <= 16'd256) ? int'(len) - 1 : 0;
        sum = len[15:8] + len[7:0] + code;
        send_byte(8'h01);
        send_byte(len[15:8]);
        send_byte(len[7:0]);
        send_byte(code);
        for (int i = 0; i < n; i++) begin
            send_byte(base + 8'(i));
            sum = sum + base + 8'(i);
        end
        send_byte(8'h00 - sum + sumErr);
        send_byte(endByte);
        release_line();
    endtask
endmodule

// file: sim/bcpp_parser_asserts.sv
// Concurrent checks on the parser's ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module bcpp_parser_asserts (
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire logic                 clkEn,
    input wire logic                 rxValid,
    input wire bcpp_pkg::bcpp_byte_t rxByte,
    input wire logic                 cmdDone,
    input wire logic                 cmdFlashErr,
    input wire logic [31:0]          cmdFailAddr,
    input wire logic [7:0]           infoRdAddr,
    input wire bcpp_pkg::bcpp_byte_t infoRdData,
    input wire logic                 cmdStart,
    input wire bcpp_pkg::bcpp_byte_t cmdCode,
    input wire bcpp_pkg::bcpp_len_t  cmdLen,
    input wire logic                 replyValid,
    input wire bcpp_pkg::bcpp_byte_t replyStart,
    input wire bcpp_pkg::bcpp_byte_t replyEnd,
    input wire bcpp_pkg::bcpp_byte_t responseCode,
    input wire logic [31:0]          failAddr,
    input wire logic                 busy
);
    import bcpp_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire takeDone = busy && cmdDone && clkEn;

    AST_REPLY_FRAME: assert property (
        replyValid |-> replyStart == 8'h81 && replyEnd == 8'h03)
        else $error("reply markers wrong");
    AST_FAIL_ADDR: assert property (
        takeDone && cmdFlashErr |=> replyValid && failAddr == $past(cmdFailAddr))
        else $error("failure address not reported");
    AST_NO_FAIL: assert property (
        takeDone && !cmdFlashErr |=> replyValid && failAddr == 32'h0fffffff &&
        responseCode == cmdCode)
        else $error("clean completion reply wrong");
    AST_START_EXEC: assert property (cmdStart |-> busy ##1 !cmdStart)
        else $error("accepted command not executing");
    AST_DONE_IDLE: assert property (takeDone |=> !busy && !cmdStart)
        else $error("execution did not end");
    AST_HOLD_EXEC: assert property (
        busy && !cmdDone |=> busy && $stable(cmdCode) && $stable(cmdLen))
        else $error("bytes taken while executing");
    AST_ERR_CODE: assert property (
        replyValid && !$past(busy) |-> responseCode inside {8'h80, 8'h81, 8'h82, 8'hff})
        else $error("error reply code not distinct");
    AST_FREEZE: assert property (
        !clkEn |=> $stable(busy) && $stable(replyValid) && $stable(cmdStart) &&
        $stable(cmdLen) && $stable(responseCode) && $stable(infoRdData))
        else $error("state moved while clock enable low");
    AST_EXCL: assert property (!(cmdStart && replyValid))
        else $error("error reply with execution");
    AST_REPLY_PULSE: assert property (replyValid |=> !replyValid && !busy)
        else $error("not back to waiting after reply");
endmodule

bind bcpp_parser bcpp_parser_asserts bcpp_parser_asserts_i (.*);

// file: sim/test_boot_command_packet_parser.sv
// Bench of the parser: host model, executor and reply scoreboard.
// Assumes replies one cycle after the end byte or after done.
`timescale 1ns/1ps
module test_boot_command_packet_parser;
    import bcpp_pkg::*;
    logic        ref_clk, rst, clkEn, rxValid, cmdDone, cmdFlashErr, cmdStart, replyValid, busy;
    logic [31:0] cmdFailAddr, failAddr;
    logic [7:0]  infoRdAddr;
    logic [40:0] expQ[$];
    logic [40:0] e;
    bcpp_byte_t  rxByte, infoRdData, cmdCode, replyStart, replyEnd, responseCode, lastCode;
    bcpp_byte_t  lastBase, nkCode;
    bcpp_len_t   cmdLen, len, lastLen;
    logic        nkReply;
    logic        rdPend = 1'b0;
    integer      seed = 44;
    int          n_mismatch = 0, num_checks = 0, outst = 0, nkSeen = 0;
    bcpp_byte_t  codes[20] = '{8'h3b, 8'h30, 8'h34, 8'h4f, 8'h4e, 8'h18, 8'h2c, 8'h71, 8'h12,
                               8'h50, 8'h00, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h52, 8'h51, 8'h15,
                               8'h3a, 8'h13};

    bcpp_parser #(.HAS_USER_KEY(1'b1)) bcpp_parser_i (.ref_clk(ref_clk), .rst(rst),
        .clkEn(clkEn), .rxValid(rxValid), .rxByte(rxByte), .cmdDone(cmdDone),
        .cmdFlashErr(cmdFlashErr), .cmdFailAddr(cmdFailAddr), .infoRdAddr(infoRdAddr),
        .infoRdData(infoRdData), .cmdStart(cmdStart), .cmdCode(cmdCode), .cmdLen(cmdLen),
        .replyValid(replyValid), .replyStart(replyStart), .replyEnd(replyEnd),
        .responseCode(responseCode), .failAddr(failAddr), .busy(busy));
    // Variant without the user key commands, fed the same stream
    bcpp_parser #(.HAS_USER_KEY(1'b0)) bcpp_parser_nokey_i (.ref_clk(ref_clk), .rst(rst),
        .clkEn(clkEn), .rxValid(rxValid), .rxByte(rxByte), .cmdDone(cmdDone),
        .cmdFlashErr(cmdFlashErr), .cmdFailAddr(cmdFailAddr), .infoRdAddr(infoRdAddr),
        .infoRdData(), .cmdStart(), .cmdCode(), .cmdLen(), .replyValid(nkReply),
        .replyStart(), .replyEnd(), .responseCode(nkCode), .failAddr(), .busy());
    bcpp_host_model bcpp_host_model_i (.ref_clk(ref_clk), .rxValid(rxValid), .rxByte(rxByte));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Executor answers after a random wait; scoreboard takes each reply
    always @(negedge ref_clk) begin
        if (rdPend && 16'(infoRdAddr) + 16'd1 < lastLen)
            check(32'(infoRdData), 32'(8'(lastBase + infoRdAddr)));
        rdPend     = (busy === 1'b1);
        infoRdAddr = 8'($random(seed));
        cmdDone    = 1'b0;
        if (nkReply === 1'b1 && (lastCode == 8'h2a || lastCode == 8'h2b)) begin
            check(32'(nkCode), 32'h80);
            nkSeen++;
        end
        if (replyValid === 1'b1) begin
            if (expQ.size() == 0)
                check(32'h1, 32'h0);
            else begin
                e = expQ.pop_front();
                check(32'(responseCode), 32'(e[39:32]));
                if (e[40])
                    check(failAddr, e[31:0]);
            end
            outst--;
        end
        if (busy === 1'b1 && ($random(seed) & 3) == 0) begin
            cmdDone     = 1'b1;
            cmdFlashErr = 1'($random(seed));
            cmdFailAddr = $random(seed);
            expQ.push_back({1'b1, lastCode, cmdFlashErr ? cmdFailAddr : 32'h0fffffff});
        end
    end

    task automatic pkt(input bcpp_len_t ln, input bcpp_byte_t code, input bcpp_byte_t sumErr,
                       input bcpp_byte_t endByte, input logic ok, input bcpp_byte_t expCode);
        int w;
        lastCode = code;
        lastLen  = ln;
        lastBase = 8'($random(seed));
        outst++;
        if (!ok)
            expQ.push_back({1'b0, expCode, 32'h0});
        bcpp_host_model_i.send_pkt(ln, code, lastBase, sumErr, endByte);
        w = 0;
        while (outst != 0 && w < 500) begin
            @(negedge ref_clk);
            w++;
        end
        check(32'(outst), 32'h0);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        rst         = 1'b1;
        clkEn       = 1'b1;
        cmdDone     = 1'b0;
        cmdFlashErr = 1'b0;
        cmdFailAddr = 32'h0;
        infoRdAddr  = 8'h00;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        check(failAddr, 32'h0fffffff);
        check(32'(busy), 32'h0);
        bcpp_host_model_i.send_byte(8'h03);
        bcpp_host_model_i.send_byte(8'h55);
        bcpp_host_model_i.release_line();
        pkt(16'h0001, 8'h00, 8'h00, 8'h03, 1'b1, 8'h00);
        $display("test noise_then_inquiry done");
        for (int i = 0; i < 20; i++) begin
            len = 16'd1 + 16'($random(seed) & 8'hff);
            if (codes[i] == 8'h50 || codes[i] == 8'h71)
                len = 16'h0003;
            if (codes[i] == 8'h00 || codes[i] == 8'h2c)
                len = 16'h0001;
            pkt(len, codes[i], 8'h00, 8'h03, 1'b1, 8'h00);
        end
        check(32'(nkSeen), 32'h2);
        $display("test command_set done");
        pkt(16'h0001, 8'h00, 8'h01, 8'h03, 1'b0, 8'h82);
        pkt(16'h0001, 8'h00, 8'h00, 8'h04, 1'b0, 8'h81);
        pkt(16'h0001, 8'h99, 8'h00, 8'h03, 1'b0, 8'h80);
        pkt(16'h0000, 8'h00, 8'h00, 8'h03, 1'b0, 8'hff);
        pkt(16'h0402, 8'h13, 8'h00, 8'h03, 1'b0, 8'hff);
        pkt(16'h012c, 8'h13, 8'h00, 8'h03, 1'b0, 8'h81);
        pkt(16'h0002, 8'h00, 8'h00, 8'h03, 1'b0, 8'h81);
        pkt(16'h0003, 8'h2c, 8'h00, 8'h03, 1'b0, 8'h81);
        $display("test error_replies done");
        @(negedge ref_clk);
        clkEn = 1'b0;
        bcpp_host_model_i.send_byte(8'h01);
        bcpp_host_model_i.send_byte(8'h01);
        bcpp_host_model_i.release_line();
        clkEn = 1'b1;
        pkt(16'h0001, 8'h00, 8'h00, 8'h03, 1'b1, 8'h00);
        $display("test clock_enable_freeze done");
        print_verdict();
    end
endmodule
